// ---- gdf_pkg.sv ----
package gdf_pkg;
	// -----------------------------------------------------------------
	// clock and timing
	// -----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned CLK_PERIOD_PS  = 25_000;
	// edge acknowledge off pulse, nominal
	localparam int unsigned ACK_NS         = 900;
	localparam int unsigned ACK_CYC        =
		(ACK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// desaturation check delay after turn-on command
	localparam int unsigned SAMPLE_NS      = 8_500;
	localparam int unsigned SAMPLE_CYC     =
		(SAMPLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// latest autonomous turn-off after turn-on command
	localparam int unsigned TOFF_MAX_NS    = 10_000;
	localparam int unsigned TOFF_MAX_CYC   =
		(TOFF_MAX_NS * 1000) / CLK_PERIOD_PS;
	// fault lockout, status light off
	localparam int unsigned LOCK_MS        = 1_000;
	localparam int unsigned LOCK_CYC       = (CLK_HZ / 1000) * LOCK_MS;
	localparam int unsigned CNT_W          = 26;

	// -----------------------------------------------------------------
	// modes and carriers
	// -----------------------------------------------------------------
	typedef enum logic {
		GDF_MODE_LOCAL,
		GDF_MODE_HOST
	} gdf_mode_t;

	typedef struct packed {
		logic gate_on;
		logic status_light;
		logic fault_active;
	} gdf_out_t;
endpackage : gdf_pkg

// ---- gdf_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdf_sync3 (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_nrst,
	// asynchronous level in, filtered level out
	input  wire logic i_async,
	output logic      o_level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// change accepted once stages two and three agree
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_level <= 1'b0;
		end else if (s2 == s3) begin
			o_level <= s3;
		end
	end
endmodule : gdf_sync3
`default_nettype wire

// ---- gdf_gate_ctrl.sv ----
// Notes on behaviour
// - local mode: fault turns switch off autonomously
// - mode selector: 1-2 local, 2-3 host
// - host mode: fault reported via status
// - host mode: gate keeps following command
// - status on when healthy, off on malfunction
// - every command edge: ~900 ns off pulse
// - local mode: off within 10 us
// - fault holds status off one second
// - gate follows command light
// - check desaturation 8.5 us after turn-on
// - undervoltage blocks turn-on
`timescale 1ns/1ps
`default_nettype none
module gdf_gate_ctrl #(
	parameter int unsigned LOCK_CYC = gdf_pkg::LOCK_CYC
) (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_nrst,
	// optical command, light = on
	input  wire logic i_cmd_light,
	// mode selector strap: high = positions 2-3 bridged
	input  wire logic i_fault_mode_selector,
	// analog monitors
	input  wire logic i_desat,
	input  wire logic i_undervolt,
	// outputs
	output logic      o_gate_on,
	output logic      o_status_light,
	output logic      o_fault_active
);
	// -----------------------------------------------------------------
	// input conditioning
	// -----------------------------------------------------------------
	logic cmd;
	logic desat;
	logic uv;
	logic cmd_d;
	logic sel;

	// every input comes from the optical side, the analog side or the strap, so each gets
	// the full three-stage filter; a single-cycle glitch is ignored
	gdf_sync3 u_cmd (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_async (i_cmd_light),
		.o_level (cmd)
	);
	gdf_sync3 u_desat (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_async (i_desat),
		.o_level (desat)
	);
	gdf_sync3 u_uv (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_async (i_undervolt),
		.o_level (uv)
	);
	gdf_sync3 u_sel (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_async (i_fault_mode_selector),
		.o_level (sel)
	);

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			cmd_d <= 1'b0;
		end else begin
			cmd_d <= cmd;
		end
	end

	logic rise;
	logic edge_ev;
	assign rise    = cmd & ~cmd_d;
	assign edge_ev = cmd ^ cmd_d;

	// -----------------------------------------------------------------
	// mode capture
	// -----------------------------------------------------------------
	// the strap is static; it is taken while the command is off so a
	// fiddled jumper never changes behaviour inside a pulse
	gdf_pkg::gdf_mode_t mode;

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			mode <= gdf_pkg::GDF_MODE_LOCAL;
		end else if (!cmd) begin
			mode <= sel ? gdf_pkg::GDF_MODE_HOST
				: gdf_pkg::GDF_MODE_LOCAL;
		end
	end

	// -----------------------------------------------------------------
	// desaturation check timer
	// -----------------------------------------------------------------
	// every interval is a count of system clocks, so a new clock rate
	// needs the package constants retuned and, for a faster clock, the 9-bit and 6-bit counters here widened
	localparam logic [8:0] SAMPLE_CNT = 9'(gdf_pkg::SAMPLE_CYC);
	localparam logic [8:0] TOFF_CNT   = 9'(gdf_pkg::TOFF_MAX_CYC);
	logic [8:0] on_cnt;
	logic       timing;
	logic       sample_ev;

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			on_cnt <= '0;
			timing <= 1'b0;
		end else if (rise) begin
			on_cnt <= 9'h001;
			timing <= 1'b1;
		end else if (!cmd) begin
			timing <= 1'b0;
		end else if (timing) begin
			on_cnt <= on_cnt + 9'h001;
			if (on_cnt == SAMPLE_CNT) begin
				timing <= 1'b0;
			end
		end
	end

	// limitation: a short that appears after the check goes unseen until
	// the next turn-on; this only guards against turning on into a short
	// sampled SAMPLE_CNT cycles after the edge, well inside TOFF_CNT
	assign sample_ev = timing && cmd && (on_cnt == SAMPLE_CNT)
		&& (SAMPLE_CNT < TOFF_CNT);

	// -----------------------------------------------------------------
	// fault lockout
	// -----------------------------------------------------------------
	// a fresh fault inside the lockout restarts the full second
	logic [gdf_pkg::CNT_W-1:0] lock_cnt;
	logic                      fault;
	localparam logic [gdf_pkg::CNT_W-1:0] LOCK_LAST =
		gdf_pkg::CNT_W'(LOCK_CYC - 1);

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			fault    <= 1'b0;
			lock_cnt <= '0;
		end else if (sample_ev && desat) begin
			fault    <= 1'b1;
			lock_cnt <= '0;
		end else if (fault) begin
			if (lock_cnt == LOCK_LAST) begin
				fault <= 1'b0;
			end else begin
				lock_cnt <= lock_cnt + 1'b1;
			end
		end
	end

	// local-mode trip: switch stays off until the command drops
	logic trip;
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			trip <= 1'b0;
		end else if (sample_ev && desat
			&& mode == gdf_pkg::GDF_MODE_LOCAL) begin
			trip <= 1'b1;
		end else if (!cmd) begin
			trip <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// edge acknowledge pulse
	// -----------------------------------------------------------------
	// a second edge inside the pulse restarts it, so the host sees one
	// longer dark interval rather than two
	localparam logic [5:0] ACK_CNT = 6'(gdf_pkg::ACK_CYC);
	logic [5:0] ack_cnt;

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			ack_cnt <= '0;
		end else if (edge_ev) begin
			ack_cnt <= ACK_CNT;
		end else if (ack_cnt != 6'h00) begin
			ack_cnt <= ack_cnt - 6'h01;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	// trip is applied combinationally too so the switch drops at the
	// clock edge that ends the check cycle, not one cycle later
	logic next_gate;
	logic next_status;
	always_comb begin
		next_gate = cmd && !uv;
		if (trip || (sample_ev && desat
			&& mode == gdf_pkg::GDF_MODE_LOCAL)) begin
			next_gate = 1'b0;
		end
		// undervoltage counts as a malfunction, so it darkens the status
		// fault reported in both modes; in host mode nothing else
		next_status = !(fault || uv || ack_cnt != 6'h00
			|| edge_ev);
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_gate_on      <= 1'b0;
			o_status_light <= 1'b0;
			o_fault_active <= 1'b0;
		end else begin
			o_gate_on      <= next_gate;
			o_status_light <= next_status;
			o_fault_active <= fault;
		end
	end
endmodule : gdf_gate_ctrl
`default_nettype wire

// ---- gdf_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdf_checker (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_cmd_light,
	input wire logic i_fault_mode_selector,
	input wire logic i_desat,
	input wire logic i_undervolt,
	input wire logic o_gate_on,
	input wire logic o_status_light,
	input wire logic o_fault_active
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// 8 cycles covers sync plus output register
	property p_uv; i_undervolt[*8] |-> !o_gate_on && !o_status_light;
	endproperty
	a_uv: assert property (p_uv) else $error("gate on in undervoltage");
	property p_ack; $changed(i_cmd_light) ##1 $stable(i_cmd_light)[*4]
		|-> ##[0:2] !o_status_light; endproperty
	a_ack: assert property (p_ack) else $error("no edge acknowledge");
	property p_len; $fell(o_status_light) |=> !o_status_light[*8]; endproperty
	a_len: assert property (p_len) else $error("status pulse too short");
	property p_lock; $rose(o_status_light) |-> !o_fault_active; endproperty
	a_lock: assert property (p_lock) else $error("status on in lockout");
	property p_loc; $rose(o_fault_active) && !i_fault_mode_selector
		|-> ##[0:2] !o_gate_on; endproperty
	a_loc: assert property (p_loc) else $error("local trip kept gate");
	property p_host; $rose(o_fault_active) && i_fault_mode_selector
		&& i_cmd_light |=> o_gate_on; endproperty
	a_host: assert property (p_host) else $error("host mode gate off");
	property p_on; $rose(o_gate_on) |-> $past(i_cmd_light, 4); endproperty
	a_on: assert property (p_on) else $error("gate on without command");
	property p_smp; $rose(o_fault_active) |-> $past(o_gate_on, 300);
	endproperty
	a_smp: assert property (p_smp) else $error("fault before sample");
endmodule : gdf_checker
bind gdf_gate_ctrl gdf_checker u_gdf_checker (.i_clock(i_clock),
	.i_nrst(i_nrst), .i_cmd_light(i_cmd_light), .i_desat(i_desat),
	.i_fault_mode_selector(i_fault_mode_selector),
	.i_undervolt(i_undervolt), .o_gate_on(o_gate_on),
	.o_status_light(o_status_light), .o_fault_active(o_fault_active));
`default_nettype wire

// ---- gdf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdf_host_model (
	input  wire logic i_clock,
	input  wire logic i_want,
	input  wire logic i_status,
	output logic      o_cmd,
	output int        o_acks
);
	int   low = 0;
	int   acks = 0;
	logic trip = 0;
	assign o_cmd  = i_want && !trip;
	assign o_acks = acks;
	always @(posedge i_clock) begin
		low <= i_status ? 0 : low + 1;
		if (i_status && low > 0 && low < 80) acks <= acks + 1;
		// long dark status is a fault: host orders the switch off
		trip <= i_want && (trip || low == 80);
	end
endmodule : gdf_host_model
`default_nettype wire

// ---- test_gate_driver_fault_feedback.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_gate_driver_fault_feedback;
	typedef struct { logic sel, desat, flt, gate; } gdf_row_t;
	logic i_clock = 0, i_nrst = 0, want = 0, sel = 0, desat = 0, uv = 0;
	logic cmd, gate, stat, flt;
	int   acks, n, error_cnt = 0, total_checks = 0;
	gdf_row_t rows [4] = '{'{0,0,0,1}, '{1,0,0,1}, '{0,1,1,0}, '{1,1,1,1}};
	always #12.5 i_clock = ~i_clock;
	gdf_host_model u_gdf_host_model (.i_clock(i_clock), .i_want(want),
		.i_status(stat), .o_cmd(cmd), .o_acks(acks));
	gdf_gate_ctrl #(.LOCK_CYC(1000)) u_gdf_gate_ctrl (.i_clock(i_clock),
		.i_nrst(i_nrst), .i_cmd_light(cmd), .i_fault_mode_selector(sel),
		.i_desat(desat), .i_undervolt(uv), .o_gate_on(gate),
		.o_status_light(stat), .o_fault_active(flt));
	task check(input logic [31:0] seen, exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task cyc(input int k);
		repeat (k) @(posedge i_clock);
		#1;
	endtask : cyc
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	initial begin
		#1000000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		cyc(16);
		check(stat, 0, "status in reset");
		@(posedge i_clock) i_nrst <= 1;
		cyc(10);
		check(stat, 1, "status healthy");
		$display("reset test done");
		foreach (rows[i]) begin
			@(posedge i_clock) {sel, desat} <= {rows[i].sel, rows[i].desat};
			cyc(2);
			@(posedge i_clock) want <= 1;
			cyc(360);
			check(flt, rows[i].flt, "fault");
			check(gate, rows[i].gate, "gate");
			check(stat, !rows[i].flt, "status");
			cyc(100);
			check(gate, !rows[i].flt, "gate after host order");
			@(posedge i_clock) {want, desat} <= 2'h0;
			cyc(1100);
			check(stat, 1, "status after lockout");
			$display("row %0d done", i);
		end
		@(posedge i_clock) want <= 1;
		n = 0;
		while (stat && n < 20) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (!stat && n < 100) begin
			cyc(1);
			n++;
		end
		check(n, gdf_pkg::ACK_CYC + 1, "ack length");
		check(gate, 1, "gate follows command");
		$display("ack test done");
		@(posedge i_clock) uv <= 1;
		cyc(10);
		check(gate, 0, "gate in undervoltage");
		check(stat, 0, "status in undervoltage");
		@(posedge i_clock) {uv, want} <= 2'h0;
		cyc(60);
		check(32'(acks >= 2), 1, "acks seen");
		$display("undervoltage test done");
		give_verdict();
	end
endmodule : test_gate_driver_fault_feedback
`default_nettype wire
